// ### design/pbp_config_regs.sv
// What this block does
// - The phase-8 balance gain is a three-bit code from 0.65x to 1.23x that resets to 100, meaning 1x.
// - Phase-7 offset bits 6:4 add on-time in 30mV steps over the reference input, resetting to 0.
// - Phase-8 offset bits 6:4 use the same 30mV-step encoding and also reset to 0.
// - Bits 3:0 of each offset register return the chip's factory trim and ignore writes.
// - Over-current gains for phases 1 to 4 sit two bits each in the low gain register, 00 = 1x.
// - Over-current gains for phases 5 to 8 sit two bits each in the high gain register.
// - The summed over-current guard waits 112, 56, 28 or 14us by code, with 56us after reset.
// - Bit 5 of the adjust register picks whether the offset raises (0) or lowers (1) the limit.
// - The summed over-current limit is 2.2V plus or minus the five-bit code times 50mV.
// - The absolute over-voltage code picks 2V, 1.8V, 2.2V or 2.4V, with 2V after reset.
`default_nettype none

module pbp_config_regs
  import pbp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire pbp_trim_t i_trim,
  input wire logic i_sum_over,
  output logic o_sda_out,
  output logic o_sda_oe,
  output pbp_cfg_t o_cfg,
  output logic [11:0] o_sum_limit_mv,
  output logic o_sum_trip
);

  pbp_state_t st_q;
  pbp_cfg_t cfg_q;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic ack_q;
  logic rw_q;
  logic mack_q;

  // Bus pins are taken as already synchronous, so one delayed copy finds edges
  wire logic scl_rise = i_scl & ~scl_q;
  wire logic scl_fall = ~i_scl & scl_q;
  wire logic bus_start = scl_q & i_scl & sda_q & ~i_sda;
  wire logic bus_stop = scl_q & i_scl & ~sda_q & i_sda;
  wire logic byte_done = scl_fall & (cnt_q == 4'h8) & ~ack_q;
  wire logic ack_end = scl_fall & ack_q;
  wire logic addr_hit = (sh_q[7:1] == DEV_ADDR);
  wire logic wr_fire = byte_done & (st_q == PBP_ST_WR);

  wire logic sel_p7_off = (ptr_q == PBP_OFS_P7_OFFSET);
  wire logic sel_p8_gain = (ptr_q == PBP_OFS_P8_GAIN);
  wire logic sel_p8_off = (ptr_q == PBP_OFS_P8_OFFSET);
  wire logic sel_ocp_lo = (ptr_q == PBP_OFS_OCP_LOW);
  wire logic sel_ocp_hi = (ptr_q == PBP_OFS_OCP_HIGH);
  wire logic sel_dly = (ptr_q == PBP_OFS_SUMMED_OVERCURRENT_GUARD_DLY);
  wire logic sel_adj = (ptr_q == PBP_OFS_SUMMED_OVERCURRENT_GUARD_ADJ);
  wire logic sel_ovp = (ptr_q == PBP_OFS_ABS_OVP);

  // Write strobes, one per register; unmapped offsets get none
  wire logic wr_p7_off = wr_fire & sel_p7_off;
  wire logic wr_p8_gain = wr_fire & sel_p8_gain;
  wire logic wr_p8_off = wr_fire & sel_p8_off;
  wire logic wr_ocp_lo = wr_fire & sel_ocp_lo;
  wire logic wr_ocp_hi = wr_fire & sel_ocp_hi;
  wire logic wr_dly = wr_fire & sel_dly;
  wire logic wr_adj = wr_fire & sel_adj;
  wire logic wr_ovp = wr_fire & sel_ovp;

  // Unmapped offsets and unused upper bits read as zero
  wire logic [7:0] rd_byte =
      ({8{sel_p7_off}} & {1'b0, cfg_q.p7_offset, i_trim.p7}) |
      ({8{sel_p8_gain}} & {5'h00, cfg_q.p8_gain}) |
      ({8{sel_p8_off}} & {1'b0, cfg_q.p8_offset, i_trim.p8}) |
      ({8{sel_ocp_lo}} & 8'(cfg_q.ocp_gain[3:0])) |
      ({8{sel_ocp_hi}} & 8'(cfg_q.ocp_gain[7:4])) |
      ({8{sel_dly}} & {6'h00, cfg_q.summed_overcurrent_guard_delay}) |
      ({8{sel_adj}} & {2'h0, cfg_q.summed_overcurrent_guard_dir, cfg_q.summed_overcurrent_guard_offset}) |
      ({8{sel_ovp}} & {6'h00, cfg_q.abs_ovp});

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Register writes; trim bits and unused upper bits are never stored
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_q <= PBP_CFG_RST;
    end else begin
      if (wr_p7_off) cfg_q.p7_offset <= sh_q[PBP_OFFSET_MSB:PBP_OFFSET_LSB];
      if (wr_p8_gain) cfg_q.p8_gain <= sh_q[2:0];
      if (wr_p8_off) cfg_q.p8_offset <= sh_q[PBP_OFFSET_MSB:PBP_OFFSET_LSB];
      if (wr_ocp_lo) cfg_q.ocp_gain[3:0] <= sh_q;
      if (wr_ocp_hi) cfg_q.ocp_gain[7:4] <= sh_q;
      if (wr_dly) cfg_q.summed_overcurrent_guard_delay <= sh_q[1:0];
      if (wr_adj) cfg_q.summed_overcurrent_guard_dir <= sh_q[PBP_SUMMED_OVERCURRENT_GUARD_DIR_BIT];
      if (wr_adj) cfg_q.summed_overcurrent_guard_offset <= sh_q[4:0];
      if (wr_ovp) cfg_q.abs_ovp <= sh_q[1:0];
    end
  end

  // Serial engine: bits are sampled on the SCL rise and driven after the fall
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_q <= PBP_ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (bus_start) begin
      st_q <= PBP_ST_ADDR;
      cnt_q <= 4'h0;
      ack_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st_q <= PBP_ST_IDLE;
      ack_q <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      if (scl_rise && !ack_q && st_q != PBP_ST_IDLE && st_q != PBP_ST_RD) begin
        sh_q <= {sh_q[6:0], i_sda};
        cnt_q <= cnt_q + 4'h1;
      end
      if (scl_rise && ack_q && st_q == PBP_ST_RD) begin
        mack_q <= ~i_sda;
      end
      unique case (st_q)
        PBP_ST_IDLE: begin
          o_sda_oe <= 1'b0;
        end
        PBP_ST_ADDR, PBP_ST_REG, PBP_ST_WR: begin
          if (byte_done) begin
            if (st_q == PBP_ST_ADDR && !addr_hit) begin
              st_q <= PBP_ST_IDLE;
            end else begin
              ack_q <= 1'b1;
              o_sda_oe <= 1'b1;
            end
            if (st_q == PBP_ST_ADDR) rw_q <= sh_q[0];
            if (st_q == PBP_ST_REG) ptr_q <= sh_q;
            if (st_q == PBP_ST_WR) ptr_q <= ptr_q + 8'h01;
          end else if (ack_end) begin
            ack_q <= 1'b0;
            cnt_q <= 4'h0;
            o_sda_oe <= 1'b0;
            if (st_q == PBP_ST_ADDR && rw_q) begin
              st_q <= PBP_ST_RD;
              tx_q <= {rd_byte[6:0], 1'b0};
              o_sda_oe <= ~rd_byte[7];
              ptr_q <= ptr_q + 8'h01;
              cnt_q <= 4'h1;
            end else if (st_q == PBP_ST_ADDR) begin
              st_q <= PBP_ST_REG;
            end else begin
              st_q <= PBP_ST_WR;
            end
          end
        end
        PBP_ST_RD: begin
          if (scl_fall && !ack_q && cnt_q != 4'h8) begin
            o_sda_oe <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            ack_q <= 1'b1;
            o_sda_oe <= 1'b0;
          end else if (ack_end) begin
            ack_q <= 1'b0;
            // A master NACK ends the read; the pointer has already moved on
            if (mack_q) begin
              tx_q <= {rd_byte[6:0], 1'b0};
              o_sda_oe <= ~rd_byte[7];
              ptr_q <= ptr_q + 8'h01;
              cnt_q <= 4'h1;
            end else begin
              st_q <= PBP_ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sda_out <= 1'b0;
      o_cfg <= PBP_CFG_RST;
    end else begin
      o_sda_out <= 1'b0;
      o_cfg <= cfg_q;
    end
  end

  pbp_sum_guard u_sum_guard (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .i_over(i_sum_over),
    .i_delay(cfg_q.summed_overcurrent_guard_delay),
    .i_dir(cfg_q.summed_overcurrent_guard_dir),
    .i_offset(cfg_q.summed_overcurrent_guard_offset),
    .o_limit_mv(o_sum_limit_mv),
    .o_trip(o_sum_trip)
  );

endmodule : pbp_config_regs

`default_nettype wire

// ### design/pbp_pkg.sv
`default_nettype none

package pbp_pkg;

  // Register offsets
  localparam logic [7:0] PBP_OFS_P7_OFFSET = 8'h1E;
  localparam logic [7:0] PBP_OFS_P8_GAIN = 8'h1F;
  localparam logic [7:0] PBP_OFS_P8_OFFSET = 8'h20;
  localparam logic [7:0] PBP_OFS_OCP_LOW = 8'h21;
  localparam logic [7:0] PBP_OFS_OCP_HIGH = 8'h22;
  localparam logic [7:0] PBP_OFS_SUMMED_OVERCURRENT_GUARD_DLY = 8'h23;
  localparam logic [7:0] PBP_OFS_SUMMED_OVERCURRENT_GUARD_ADJ = 8'h24;
  localparam logic [7:0] PBP_OFS_ABS_OVP = 8'h25;

  // Field positions
  localparam int PBP_OFFSET_LSB = 4;
  localparam int PBP_OFFSET_MSB = 6;
  localparam int PBP_SUMMED_OVERCURRENT_GUARD_DIR_BIT = 5;

  // Reset values
  localparam logic [2:0] PBP_RST_P8_GAIN = 3'h4;
  localparam logic [2:0] PBP_RST_OFFSET = 3'h0;
  localparam logic [1:0] PBP_RST_OCP_GAIN = 2'h0;
  localparam logic [1:0] PBP_RST_SUMMED_OVERCURRENT_GUARD_DLY = 2'h1;
  localparam logic [5:0] PBP_RST_SUMMED_OVERCURRENT_GUARD_ADJ = 6'h00;
  localparam logic [1:0] PBP_RST_ABS_OVP = 2'h0;

  // Summed over-current delay times and their cycle counts
  localparam int unsigned PBP_CLK_PERIOD_NS = 50;
  localparam int unsigned PBP_SUMMED_OVERCURRENT_GUARD_T0_NS = 112000;
  localparam int unsigned PBP_SUMMED_OVERCURRENT_GUARD_T1_NS = 56000;
  localparam int unsigned PBP_SUMMED_OVERCURRENT_GUARD_T2_NS = 28000;
  localparam int unsigned PBP_SUMMED_OVERCURRENT_GUARD_T3_NS = 14000;
  localparam logic [11:0] PBP_SUMMED_OVERCURRENT_GUARD_C0 = 12'(PBP_SUMMED_OVERCURRENT_GUARD_T0_NS / PBP_CLK_PERIOD_NS);
  localparam logic [11:0] PBP_SUMMED_OVERCURRENT_GUARD_C1 = 12'(PBP_SUMMED_OVERCURRENT_GUARD_T1_NS / PBP_CLK_PERIOD_NS);
  localparam logic [11:0] PBP_SUMMED_OVERCURRENT_GUARD_C2 = 12'(PBP_SUMMED_OVERCURRENT_GUARD_T2_NS / PBP_CLK_PERIOD_NS);
  localparam logic [11:0] PBP_SUMMED_OVERCURRENT_GUARD_C3 = 12'(PBP_SUMMED_OVERCURRENT_GUARD_T3_NS / PBP_CLK_PERIOD_NS);

  // Summed over-current limit in millivolts
  localparam logic [11:0] PBP_SUMMED_OVERCURRENT_GUARD_BASE_MV = 12'h898;
  localparam logic [11:0] PBP_SUMMED_OVERCURRENT_GUARD_STEP_MV = 12'h032;

  typedef struct packed {
    logic [2:0] p7_offset;
    logic [2:0] p8_gain;
    logic [2:0] p8_offset;
    logic [7:0][1:0] ocp_gain;
    logic [1:0] summed_overcurrent_guard_delay;
    logic summed_overcurrent_guard_dir;
    logic [4:0] summed_overcurrent_guard_offset;
    logic [1:0] abs_ovp;
  } pbp_cfg_t;

  typedef struct packed {
    logic [3:0] p7;
    logic [3:0] p8;
  } pbp_trim_t;

  localparam pbp_cfg_t PBP_CFG_RST = '{
    p7_offset: PBP_RST_OFFSET,
    p8_gain: PBP_RST_P8_GAIN,
    p8_offset: PBP_RST_OFFSET,
    ocp_gain: {8{PBP_RST_OCP_GAIN}},
    summed_overcurrent_guard_delay: PBP_RST_SUMMED_OVERCURRENT_GUARD_DLY,
    summed_overcurrent_guard_dir: PBP_RST_SUMMED_OVERCURRENT_GUARD_ADJ[5],
    summed_overcurrent_guard_offset: PBP_RST_SUMMED_OVERCURRENT_GUARD_ADJ[4:0],
    abs_ovp: PBP_RST_ABS_OVP
  };

  typedef enum logic [2:0] {
    PBP_ST_IDLE,
    PBP_ST_ADDR,
    PBP_ST_REG,
    PBP_ST_WR,
    PBP_ST_RD
  } pbp_state_t;

endpackage : pbp_pkg

`default_nettype wire

// ### design/pbp_sum_guard.sv
`default_nettype none

module pbp_sum_guard
  import pbp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_over,
  input wire logic [1:0] i_delay,
  input wire logic i_dir,
  input wire logic [4:0] i_offset,
  output logic [11:0] o_limit_mv,
  output logic o_trip
);

  logic [11:0] cnt_q;
  wire logic [11:0] dly_cycles;
  wire logic [11:0] step_mv;

  assign dly_cycles = (i_delay == 2'h0) ? PBP_SUMMED_OVERCURRENT_GUARD_C0 :
                      (i_delay == 2'h1) ? PBP_SUMMED_OVERCURRENT_GUARD_C1 :
                      (i_delay == 2'h2) ? PBP_SUMMED_OVERCURRENT_GUARD_C2 : PBP_SUMMED_OVERCURRENT_GUARD_C3;
  assign step_mv = 12'(i_offset * PBP_SUMMED_OVERCURRENT_GUARD_STEP_MV);

  // Trip only after the excess has lasted the whole delay; any dip restarts it
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 12'h000;
      o_trip <= 1'b0;
    end else if (!i_over) begin
      cnt_q <= 12'h000;
      o_trip <= 1'b0;
    end else if (cnt_q == dly_cycles - 12'h001) begin
      o_trip <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_limit_mv <= PBP_SUMMED_OVERCURRENT_GUARD_BASE_MV;
    end else begin
      o_limit_mv <= i_dir ? PBP_SUMMED_OVERCURRENT_GUARD_BASE_MV - step_mv : PBP_SUMMED_OVERCURRENT_GUARD_BASE_MV + step_mv;
    end
  end

endmodule : pbp_sum_guard

`default_nettype wire

// ### testbench/pbp_i2c_master.sv
`default_nettype none
module pbp_i2c_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic clk_n(input int n);
    repeat (n) @(negedge i_clk);
  endtask : clk_n
  // Data moves only while the clock line is low, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    clk_n(2);
    o_scl = 1'b1;
    clk_n(3);
    r = i_sda;
    o_scl = 1'b0;
    clk_n(1);
  endtask : bit_io
  task automatic start();
    o_sda_low = 1'b0;
    clk_n(2);
    o_scl = 1'b1;
    clk_n(3);
    o_sda_low = 1'b1;
    clk_n(3);
    o_scl = 1'b0;
    clk_n(2);
  endtask : start
  task automatic stop();
    o_sda_low = 1'b1;
    clk_n(2);
    o_scl = 1'b1;
    clk_n(3);
    o_sda_low = 1'b0;
    clk_n(3);
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ai, a);
  endtask : xfer
endmodule : pbp_i2c_master
`default_nettype wire

// ### testbench/pbp_config_regs_assertions.sv
`default_nettype none
module pbp_config_regs_chk
  import pbp_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sum_over,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  input wire pbp_cfg_t o_cfg,
  input wire logic [11:0] o_sum_limit_mv,
  input wire logic o_sum_trip
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  logic [11:0] run_q;
  logic [11:0] off_mv;
  assign off_mv = 12'(o_cfg.summed_overcurrent_guard_offset) * 12'h032;
  // Saturates so a long overload never wraps back into the trip window
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) run_q <= 12'h000;
    else if (!i_sum_over) run_q <= 12'h000;
    else if (run_q != 12'hFFF) run_q <= run_q + 12'h001;
  end
  function automatic logic [11:0] wait_n(input logic [1:0] c);
    return 12'h118 << (2'h3 - c);
  endfunction : wait_n
  sda_out_zero_a: assert property (o_sda_out == 1'b0)
    else $error("sda drive value not zero");
  reset_cfg_a: assert property ($rose(i_rst_b) |-> o_cfg == PBP_CFG_RST)
    else $error("config not at reset values");
  trip_delay_a: assert property ($rose(o_sum_trip) |-> run_q == wait_n(o_cfg.summed_overcurrent_guard_delay))
    else $error("trip delay wrong");
  trip_clear_a: assert property (!i_sum_over |-> ##[1:2] !o_sum_trip)
    else $error("trip not cleared");
  trip_hold_a: assert property (o_sum_trip && i_sum_over |=> o_sum_trip)
    else $error("trip dropped during overload");
  limit_calc_a: assert property (o_sum_limit_mv == (o_cfg.summed_overcurrent_guard_dir ?
    12'h898 - off_mv : 12'h898 + off_mv)) else $error("limit mismatch");
  cfg_ack_a: assert property ($changed(o_cfg) |-> o_sda_oe)
    else $error("config changed outside write ack");
  oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
    else $error("sda enable moved with clock high");
  cover property ($rose(o_sum_trip));
  cover property ($changed(o_cfg));
  cover property (o_cfg.summed_overcurrent_guard_dir && o_sum_limit_mv < 12'h898);
endmodule : pbp_config_regs_chk
bind pbp_config_regs pbp_config_regs_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
  .i_scl(i_scl), .i_sum_over(i_sum_over), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
  .o_cfg(o_cfg), .o_sum_limit_mv(o_sum_limit_mv), .o_sum_trip(o_sum_trip));
`default_nettype wire

// ### testbench/pbp_config_regs_tb.sv
`default_nettype none
module pbp_config_regs_tb;
  import pbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADR = 7'h2A; // Arbitrary bus address
  logic clk, rst_b, sum_over, scl, m_low, oe, trip;
  wire logic sda_w;
  pbp_trim_t trim;
  pbp_cfg_t cfg;
  logic [11:0] lim;
  logic [7:0] sh [8'h1E:8'h25];
  logic [15:0] cl [6] = '{16'h1EFF, 16'h20FF, 16'h243F, 16'h241F, 16'h1FFF, 16'h26FF};
  int fails = 0, n_tests = 0, seed = 51, cnt;
  logic [7:0] q;
  logic a_m;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Pull-up on the data wire; either side may pull it low
  assign sda_w = ~(m_low | oe);
  pbp_i2c_master u_m (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda_low(m_low));
  pbp_config_regs #(.DEV_ADDR(ADR)) DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_scl(scl),
    .i_sda(sda_w), .i_trim(trim), .i_sum_over(sum_over), .o_sda_out(), .o_sda_oe(oe),
    .o_cfg(cfg), .o_sum_limit_mv(lim), .o_sum_trip(trip));
  task automatic summarize();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] msk(input logic [7:0] p);
    case (p)
      8'h1E, 8'h20: return 8'h70;
      8'h1F: return 8'h07;
      8'h21, 8'h22: return 8'hFF;
      8'h24: return 8'h3F;
      8'h23, 8'h25: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : msk
  function automatic logic [7:0] rdx(input logic [7:0] p);
    if (msk(p) == 8'h00) return 8'h00;
    return (sh[p] & msk(p)) | (p == 8'h1E ? {4'h0, trim.p7} :
      p == 8'h20 ? {4'h0, trim.p8} : 8'h00);
  endfunction : rdx
  function automatic pbp_cfg_t ecfg();
    return '{sh[8'h1E][6:4], sh[8'h1F][2:0], sh[8'h20][6:4], {sh[8'h22], sh[8'h21]},
      sh[8'h23][1:0], sh[8'h24][5], sh[8'h24][4:0], sh[8'h25][1:0]};
  endfunction : ecfg
  function automatic logic [11:0] elim();
    logic [11:0] o;
    o = 12'(sh[8'h24][4:0]) * 12'h032;
    return sh[8'h24][5] ? 12'h898 - o : 12'h898 + o;
  endfunction : elim
  task automatic adr(input logic [7:0] p);
    logic a;
    u_m.start();
    u_m.xfer({ADR, 1'b0}, 1'b1, q, a);
    chk("addr ack", 64'h0, 64'(a));
    u_m.xfer(p, 1'b1, q, a);
  endtask : adr
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic a;
    adr(p);
    u_m.xfer(d, 1'b1, q, a);
    chk("data ack", 64'h0, 64'(a));
    u_m.stop();
    if (msk(p) != 8'h00) sh[p] = d;
  endtask : wr
  task automatic rchk(input logic [7:0] p);
    logic a;
    adr(p);
    u_m.start();
    u_m.xfer({ADR, 1'b1}, 1'b1, q, a);
    u_m.xfer(8'hFF, 1'b1, q, a);
    u_m.stop();
    chk("reg read", 64'(rdx(p)), 64'(q));
    chk("cfg", 64'(ecfg()), 64'(cfg));
    chk("limit", 64'(elim()), 64'(lim));
  endtask : rchk
  initial begin
    rst_b = 1'b0;
    sum_over = 1'b0;
    trim = pbp_trim_t'(8'($random(seed)));
    foreach (sh[p]) sh[p] = (p == 8'h1F) ? 8'h04 : (p == 8'h23) ? 8'h01 : 8'h00;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    for (int p = 8'h1D; p <= 8'h26; p++) rchk(8'(p));
    $display("reset values done");
    foreach (cl[i]) begin
      wr(cl[i][15:8], cl[i][7:0]);
      rchk(cl[i][15:8]);
    end
    $display("corner writes done");
    // Auto-increment: a two-byte write, then a read that ACKs once and NACKs the last byte
    adr(8'h21);
    u_m.xfer(8'hA5, 1'b1, q, a_m);
    u_m.xfer(8'h3C, 1'b1, q, a_m);
    u_m.stop();
    sh[8'h21] = 8'hA5;
    sh[8'h22] = 8'h3C;
    rchk(8'h21);
    adr(8'h21);
    u_m.start();
    u_m.xfer({ADR, 1'b1}, 1'b1, q, a_m);
    u_m.xfer(8'hFF, 1'b0, q, a_m);
    chk("burst first", 64'(rdx(8'h21)), 64'(q));
    u_m.xfer(8'hFF, 1'b1, q, a_m);
    u_m.stop();
    chk("burst second", 64'(rdx(8'h22)), 64'(q));
    $display("burst transfers done");
    repeat (16) begin
      wr(8'h1E + 8'($random(seed) & 7), 8'($random(seed)));
      for (int p = 8'h1E; p <= 8'h25; p++) rchk(8'(p));
    end
    $display("random writes done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h23, 8'(c));
      sum_over = 1'b1;
      // A short overload first: any low sample must restart the count
      repeat (100) @(negedge clk);
      sum_over = 1'b0;
      @(negedge clk);
      sum_over = 1'b1;
      cnt = 0;
      while (!trip && cnt < 3000) begin
        @(negedge clk);
        cnt++;
      end
      chk("trip delay", 64'h8C0 >> c, 64'(cnt));
      if (cnt == 3000) summarize();
      sum_over = 1'b0;
      repeat (2) @(negedge clk);
      chk("trip clear", 64'h0, 64'(trip));
    end
    $display("sum guard done");
    summarize();
  end
endmodule : pbp_config_regs_tb
`default_nettype wire
